// ### pdhc_ctrl.sv
`timescale 1ns/1ps
`include "pdhc_defines.svh"

module pdhc_ctrl (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [`PDHC_ADDR_W-1:0]   paddr,
    input  wire logic [`PDHC_DATA_W-1:0]   pwdata,
    output logic      [`PDHC_DATA_W-1:0]   prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      core_halted,
    input  wire logic                      engine_at_boundary,
    input  wire logic [`PDHC_NUM_EVT-1:0]  engine_events,
    output logic                           engine_freeze,
    output logic                           irq
);

    // ---------------- halt input and freeze control
    logic                 halted_sync;
    logic [1:0]           dbgctl_reg;
    logic [1:0]           dbgctl_next;
    pdhc_pkg::pdhc_state_e state_reg;
    pdhc_pkg::pdhc_state_e state_next;
    logic                 free_run;
    logic                 soft_stop;
    logic                 halt_request;
    logic                 frozen;

    pdhc_sync u_halt_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (core_halted),
        .sync_out (halted_sync)
    );

    assign free_run     = dbgctl_reg[`PDHC_DBG_FREE_BIT];
    assign soft_stop    = dbgctl_reg[`PDHC_DBG_SOFT_BIT];
    // free run masks the halt input entirely
    assign halt_request = halted_sync & ~free_run;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            pdhc_pkg::PDHC_RUN: begin
                if (halt_request) begin
                    // soft is consulted only on the freezing path
                    if (!soft_stop || engine_at_boundary) begin
                        state_next = pdhc_pkg::PDHC_FROZEN;
                    end else begin
                        state_next = pdhc_pkg::PDHC_WAITBND;
                    end
                end
            end
            pdhc_pkg::PDHC_WAITBND: begin
                if (!halt_request) begin
                    state_next = pdhc_pkg::PDHC_RUN;
                end else if (engine_at_boundary || !soft_stop) begin
                    state_next = pdhc_pkg::PDHC_FROZEN;
                end
            end
            pdhc_pkg::PDHC_FROZEN: begin
                // resume once halt falls or free run is chosen
                if (!halt_request) begin
                    state_next = pdhc_pkg::PDHC_RUN;
                end
            end
            default: begin
                state_next = pdhc_pkg::PDHC_RUN;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= pdhc_pkg::PDHC_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    assign frozen        = (state_reg == pdhc_pkg::PDHC_FROZEN);
    assign engine_freeze = frozen;

    // ---------------- bus decode
    logic setup_phase;
    logic access_phase;
    logic hit_dbgctl;
    logic hit_index;
    logic hit_enmask;
    logic hit_raw;
    logic hit_masked;
    logic hit_activity;
    logic hit_any;
    logic wr_done;
    logic rd_done;
    logic wr_dbgctl;
    logic wr_enmask;
    logic wr_raw;
    logic rd_idx;

    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable;
    assign hit_dbgctl   = (paddr == `PDHC_OFF_DBGCTL);
    assign hit_index    = (paddr == `PDHC_OFF_INDEX);
    assign hit_enmask   = (paddr == `PDHC_OFF_ENMASK);
    assign hit_raw      = (paddr == `PDHC_OFF_RAW);
    assign hit_masked   = (paddr == `PDHC_OFF_MASKED);
    assign hit_activity = (paddr == `PDHC_OFF_ACTIVITY);
    assign hit_any      = hit_dbgctl | hit_index | hit_enmask | hit_raw | hit_masked | hit_activity;

    assign pready  = 1'b1;
    assign pslverr = access_phase & ~hit_any;

    assign wr_done   = access_phase & pwrite;
    assign rd_done   = access_phase & ~pwrite;
    assign wr_dbgctl = wr_done & hit_dbgctl;
    assign wr_enmask = wr_done & hit_enmask;
    assign wr_raw    = wr_done & hit_raw;
    assign rd_idx    = rd_done & hit_index;

    // ---------------- debug control register
    // only free and soft are writable; upper bits are not stored
    assign dbgctl_next = wr_dbgctl ? (pwdata[1:0] & `PDHC_DBG_WR_MASK) : dbgctl_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbgctl_reg <= `PDHC_RST_DBGCTL;
        end else begin
            dbgctl_reg <= dbgctl_next;
        end
    end

    // ---------------- interrupt flags, mask and index
    logic [`PDHC_NUM_EVT-1:0] raw_interrupt_flags_reg;
    logic [`PDHC_NUM_EVT-1:0] raw_interrupt_flags_next;
    logic [`PDHC_NUM_EVT-1:0] interrupt_enable_mask_reg;
    logic [`PDHC_NUM_EVT-1:0] interrupt_enable_mask_next;
    logic [`PDHC_NUM_EVT-1:0] masked_interrupt_flags;
    logic [`PDHC_NUM_EVT-1:0] top_onehot;
    logic [`PDHC_NUM_EVT-1:0] sw_clear;
    logic [`PDHC_NUM_EVT-1:0] read_clear;
    logic [`PDHC_NUM_EVT-1:0] read_clear_sel;
    logic [`PDHC_NUM_EVT-1:0] captured_onehot_reg;
    logic [`PDHC_IDX_W-1:0]   top_index;

    assign masked_interrupt_flags = raw_interrupt_flags_reg & interrupt_enable_mask_reg;

    pdhc_prio u_prio (
        .flags  (masked_interrupt_flags),
        .index  (top_index),
        .onehot (top_onehot)
    );

    // the flag reported in the setup cycle is the one cleared,
    // even if a higher one arrives before the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            captured_onehot_reg <= `PDHC_RST_WORD;
        end else if (setup_phase) begin
            captured_onehot_reg <= top_onehot;
        end
    end

    assign read_clear_sel = rd_idx ? captured_onehot_reg : '0;
    assign read_clear     = read_clear_sel;
    assign sw_clear       = wr_raw ? pwdata : '0;

    // a new event wins over a clear in the same cycle
    assign raw_interrupt_flags_next = (raw_interrupt_flags_reg & ~(sw_clear | read_clear)) | engine_events;

    assign interrupt_enable_mask_next = wr_enmask ? (pwdata & `PDHC_ENMASK_WR_MASK)
                                                 : interrupt_enable_mask_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_interrupt_flags_reg   <= `PDHC_RST_WORD;
            interrupt_enable_mask_reg <= `PDHC_RST_WORD;
        end else begin
            raw_interrupt_flags_reg   <= raw_interrupt_flags_next;
            interrupt_enable_mask_reg <= interrupt_enable_mask_next;
        end
    end

    // level interrupt while any enabled flag is pending
    logic irq_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(raw_interrupt_flags_next & interrupt_enable_mask_next);
        end
    end

    assign irq = irq_reg;

    // ---------------- functional activity counter
    // stands still while frozen so work resumes exactly where it stopped
    logic [`PDHC_DATA_W-1:0] activity_reg;
    logic [`PDHC_DATA_W-1:0] activity_next;

    assign activity_next = frozen ? activity_reg : 32'(activity_reg + `PDHC_ACT_INC);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            activity_reg <= `PDHC_RST_ACT;
        end else begin
            activity_reg <= activity_next;
        end
    end

    // ---------------- read data, captured in the setup cycle
    logic [`PDHC_DATA_W-1:0] rd_mux;
    logic [`PDHC_DATA_W-1:0] prdata_reg;
    logic [`PDHC_DATA_W-1:0] rd_dbgctl;
    logic [`PDHC_DATA_W-1:0] rd_index;

    assign rd_dbgctl = {30'h00000000, dbgctl_reg};
    assign rd_index  = {24'h000000, top_index};

    assign rd_mux = hit_dbgctl   ? rd_dbgctl :
                    hit_index    ? rd_index :
                    hit_enmask   ? interrupt_enable_mask_reg :
                    hit_raw      ? raw_interrupt_flags_reg :
                    hit_masked   ? masked_interrupt_flags :
                    hit_activity ? activity_reg :
                                   `PDHC_RST_WORD;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= `PDHC_RST_WORD;
        end else if (setup_phase && !pwrite) begin
            prdata_reg <= rd_mux;
        end
    end

    assign prdata = prdata_reg;

endmodule

// ### pdhc_defines.svh
`ifndef PDHC_DEFINES_SVH
`define PDHC_DEFINES_SVH

// Behaviour
// - free bit clear: freeze while core halted
// - free bit set: ignore core halted input
// - soft bit matters only when freezing selected
// - soft clear: freeze immediately on halt
// - soft set: freeze only at resume boundary
// - debug control at 1018h, bits 1:0
// - index reports highest priority enabled pending
// - index read clears flag; zero means none
// - only unmasked flags form index and status

`define PDHC_ADDR_W          16
`define PDHC_DATA_W          32
`define PDHC_NUM_EVT         32
`define PDHC_IDX_W           8

`define PDHC_OFF_DBGCTL      16'h1018
`define PDHC_OFF_INDEX       16'h1020
`define PDHC_OFF_ENMASK      16'h1028
`define PDHC_OFF_RAW         16'h1030
`define PDHC_OFF_MASKED      16'h1038
`define PDHC_OFF_ACTIVITY    16'h1040

`define PDHC_DBG_FREE_BIT    0
`define PDHC_DBG_SOFT_BIT    1
`define PDHC_DBG_WR_MASK     2'h3
`define PDHC_RST_DBGCTL      2'h0
`define PDHC_RST_INDEX       8'h00
`define PDHC_IDX_NONE        8'h00
`define PDHC_RST_WORD        32'h00000000
`define PDHC_ENMASK_WR_MASK  32'hFFFFFFBF
`define PDHC_RST_ACT         32'h00000000
`define PDHC_ACT_INC         32'h00000001

`endif

// ### pdhc_pkg.sv
package pdhc_pkg;

    typedef enum logic [2:0] {
        PDHC_RUN     = 3'h1,
        PDHC_WAITBND = 3'h2,
        PDHC_FROZEN  = 3'h4
    } pdhc_state_e;

    typedef logic [31:0] pdhc_word_t;

endpackage

// ### pdhc_sync.sv
`timescale 1ns/1ps

module pdhc_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic async_in,
    output logic      sync_out
);

    logic stage1_reg;
    logic stage2_reg;
    logic stage3_reg;
    logic sync_reg;

    // a change counts only once stage two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
            stage3_reg <= 1'b0;
            sync_reg   <= 1'b0;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            if (stage2_reg == stage3_reg) begin
                sync_reg <= stage3_reg;
            end
        end
    end

    assign sync_out = sync_reg;

endmodule

// ### pdhc_prio.sv
`timescale 1ns/1ps
`include "pdhc_defines.svh"

module pdhc_prio (
    input  wire logic [`PDHC_NUM_EVT-1:0] flags,
    output logic      [`PDHC_IDX_W-1:0]   index,
    output logic      [`PDHC_NUM_EVT-1:0] onehot
);

    // bit 0 has the highest priority; index is bit position plus one
    always_comb begin
        index  = `PDHC_IDX_NONE;
        onehot = '0;
        for (int i = `PDHC_NUM_EVT - 1; i >= 0; i--) begin
            if (flags[i]) begin
                index  = 8'(i + 1);
                onehot = `PDHC_NUM_EVT'(1) << i;
            end
        end
    end

endmodule

// ### pdhc_checker.sv
`timescale 1ns/1ps
`include "pdhc_defines.svh"
module pdhc_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        core_halted,
    input wire logic        engine_at_boundary,
    input wire logic [31:0] engine_events,
    input wire logic        engine_freeze,
    input wire logic        irq
);
    logic [1:0] dbg_q;
    wire        acc = psel && penable;
    wire        mapped = paddr inside {`PDHC_OFF_DBGCTL, `PDHC_OFF_INDEX, `PDHC_OFF_ENMASK,
                                       `PDHC_OFF_RAW, `PDHC_OFF_MASKED, `PDHC_OFF_ACTIVITY};
    // shadow of the control bits, taken at the same edge as the register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbg_q <= 2'h0;
        end else if (acc && pwrite && paddr == `PDHC_OFF_DBGCTL) begin
            dbg_q <= pwdata[1:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // 7 cycles covers the 4 sync flops plus the state register
    sequence s_halt_held;
        (core_halted && dbg_q == 2'h0) [*7];
    endsequence
    sequence s_halt_gone;
        (!core_halted) [*7];
    endsequence
    chk_ready_always: assert property (psel |-> pready) else $error("pready low");
    chk_unmapped_err: assert property (acc |-> pslverr == !mapped) else $error("pslverr wrong");
    chk_unmapped_zero: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    chk_ctrl_readback: assert property (acc && !pwrite && paddr == `PDHC_OFF_DBGCTL |->
        prdata == {30'h0, dbg_q}) else $error("control readback wrong");
    chk_free_no_freeze: assert property (dbg_q[0] && $past(dbg_q[0]) |-> !engine_freeze)
        else $error("froze in free mode");
    chk_halt_freezes: assert property (s_halt_held |-> engine_freeze) else $error("no freeze");
    chk_halt_resumes: assert property (s_halt_gone |-> !engine_freeze) else $error("no resume");
    chk_soft_waits: assert property (dbg_q == 2'h2 && !engine_at_boundary && !engine_freeze
        |=> !engine_freeze) else $error("froze off boundary");
endmodule
bind pdhc_ctrl pdhc_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_halted(core_halted), .engine_at_boundary(engine_at_boundary),
    .engine_events(engine_events), .engine_freeze(engine_freeze), .irq(irq));

// ### pdhc_engine_model.sv
`timescale 1ns/1ps
module pdhc_engine_model (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        engine_freeze,
    input wire logic [31:0] fire,
    output logic            engine_at_boundary,
    output logic     [31:0] engine_events,
    output logic     [7:0]  work_cnt
);
    // work position only advances while not frozen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            work_cnt <= 8'h00;
        end else if (!engine_freeze) begin
            work_cnt <= work_cnt + 8'h01;
        end
    end
    // safe resume point once every eight steps
    assign engine_at_boundary = (work_cnt[2:0] == 3'h7);
    assign engine_events = engine_freeze ? 32'h0 : fire;
endmodule

// ### peripheral_debug_halt_control_tb_top.sv
`timescale 1ns/1ps
`include "pdhc_defines.svh"
module peripheral_debug_halt_control_tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        core_halted = 1'b0;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] fire = 32'h0;
    logic [31:0] rd;
    logic [31:0] a1;
    logic [7:0]  c0;
    logic        err;
    wire  [31:0] prdata;
    wire  [31:0] engine_events;
    wire  [7:0]  work_cnt;
    wire         pready;
    wire         pslverr;
    wire         engine_freeze;
    wire         engine_at_boundary;
    wire         irq;
    int          fails = 0;
    int          cmp_count = 0;
    always #2 pclk = ~pclk;
    pdhc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .core_halted(core_halted), .engine_at_boundary(engine_at_boundary),
        .engine_events(engine_events), .engine_freeze(engine_freeze), .irq(irq));
    pdhc_engine_model u_eng (.pclk(pclk), .presetn(presetn), .engine_freeze(engine_freeze),
        .fire(fire), .engine_at_boundary(engine_at_boundary), .engine_events(engine_events),
        .work_cnt(work_cnt));
    task chk(input logic [31:0] s, input logic [31:0] x);
        cmp_count++;
        if (s !== x) begin
            fails++;
            $display("ERROR %0t: got %h exp %h", $time, s, x);
        end
    endtask
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rchk(input logic [15:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(rd, x);
    endtask
    task waitf(input logic v);
        int n;
        n = 0;
        while (engine_freeze !== v && n < 40) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, engine_freeze}, {31'h0, v});
    endtask
    task pulse(input logic [31:0] b);
        @(posedge pclk);
        fire <= b;
        @(posedge pclk);
        fire <= 32'h0;
        repeat (2) @(posedge pclk);
    endtask
    task t_regs;
        rchk(`PDHC_OFF_DBGCTL, 32'h0);
        rchk(`PDHC_OFF_INDEX, 32'h0);
        apb(1'b1, `PDHC_OFF_DBGCTL, 32'hFFFFFFFF);
        rchk(`PDHC_OFF_DBGCTL, 32'h00000003);
        apb(1'b0, 16'h1024, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
    endtask
    task t_irq;
        apb(1'b1, `PDHC_OFF_DBGCTL, 32'h0);
        apb(1'b1, `PDHC_OFF_ENMASK, 32'h0000000A);
        pulse(32'h0000000B);
        chk({31'h0, irq}, 32'h1);
        rchk(`PDHC_OFF_MASKED, 32'h0000000A);
        rchk(`PDHC_OFF_INDEX, 32'h00000002);
        rchk(`PDHC_OFF_INDEX, 32'h00000004);
        rchk(`PDHC_OFF_INDEX, 32'h0);
        rchk(`PDHC_OFF_RAW, 32'h00000001);
        chk({31'h0, irq}, 32'h0);
        pulse(32'h00000008);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, `PDHC_OFF_ENMASK, 32'hFFFFFFFF);
        rchk(`PDHC_OFF_ENMASK, 32'hFFFFFFBF);
        apb(1'b1, `PDHC_OFF_ENMASK, 32'h0);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, `PDHC_OFF_RAW, 32'hFFFFFFFF);
        rchk(`PDHC_OFF_RAW, 32'h0);
    endtask
    task t_hard;
        core_halted <= 1'b1;
        waitf(1'b1);
        c0 = work_cnt;
        apb(1'b0, `PDHC_OFF_ACTIVITY, 32'h0);
        a1 = rd;
        rchk(`PDHC_OFF_ACTIVITY, a1);
        chk({24'h0, work_cnt}, {24'h0, c0});
        core_halted <= 1'b0;
        waitf(1'b0);
        repeat (3) @(posedge pclk);
        chk({31'h0, work_cnt != c0}, 32'h1);
    endtask
    task t_free;
        // free set with soft on or off never freezes
        for (int m = 1; m < 4; m += 2) begin
            apb(1'b1, `PDHC_OFF_DBGCTL, m);
            core_halted <= 1'b1;
            repeat (12) begin
                @(posedge pclk);
                chk({31'h0, engine_freeze}, 32'h0);
            end
            core_halted <= 1'b0;
        end
    endtask
    task t_soft;
        apb(1'b1, `PDHC_OFF_DBGCTL, 32'h00000002);
        core_halted <= 1'b1;
        waitf(1'b1);
        core_halted <= 1'b0;
        waitf(1'b0);
    endtask
    task results;
        $display("fails=%0d cmp_count=%0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_irq;
        t_hard;
        t_free;
        t_soft;
        results;
    end
    initial begin
        repeat (5000) @(posedge pclk);
        fails++;
        results;
    end
endmodule
